/* File: logic/sar_adc_defs.vh */
/*
  Constants for the converter conversion control: clock divider widths,
  phase lengths, source and reference select codes, result layout.
  Assumes inclusion by bare name from files under logic/.
*/
`ifndef SAR_ADC_DEFS_VH
`define SAR_ADC_DEFS_VH

// ----------------------------------------------------------------
// Timing in converter clock cycles, result and divider widths
// ----------------------------------------------------------------
`define SAMPLE_CYCLES      4'h4
`define CONVERT_CYCLES     4'hA
`define TOTAL_CYCLES       4'hE
`define RESULT_BITS        10
`define RESULT_FULL_SCALE  10'h3FF
`define DIV_WIDTH          3
`define DIV_COUNT_WIDTH    7

// ----------------------------------------------------------------
// Input source select codes
// ----------------------------------------------------------------
`define SRC_EXT0           3'h0
`define SRC_GND_LO         3'h1
`define SRC_GND_HI         3'h3
`define SRC_VDD4           3'h4

// ----------------------------------------------------------------
// Reference select codes
// ----------------------------------------------------------------
`define REF_VDD            2'h1
`define REF_AMP            2'h2

// ----------------------------------------------------------------
// Analog mux selection one-hot positions, external channel count
// ----------------------------------------------------------------
`define MUX_EXT            0
`define MUX_GND            1
`define MUX_VDD4           2
`define REF_SEL_PIN        0
`define REF_SEL_VDD        1
`define REF_SEL_AMP        2
`define EXT_CHANNELS       8

`endif

/* File: logic/adc_clock_divider.v */
/*
  Converter clock enable generator: one-cycle tick every 2^code system
  clocks. Assumes a synchronous clear when the divider must restart.
*/
`timescale 1ns/1ps
`default_nettype none

module adc_clock_divider #(
  parameter SEL_W = 3,
  parameter CNT_W = 7
) (
  input  wire             clock,
  input  wire             rst,
  input  wire             clear,
  input  wire [SEL_W-1:0] divide_code,
  output reg              tick
);

  reg  [CNT_W-1:0] count_q;
  wire [CNT_W-1:0] limit;

  // Terminal count is ratio minus one
  assign limit = (({{(CNT_W-1){1'b0}}, 1'b1} << divide_code) - {{(CNT_W-1){1'b0}}, 1'b1});

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      count_q <= {CNT_W{1'b0}};
      tick    <= 1'b0;
    end else if (clear) begin
      count_q <= {CNT_W{1'b0}};
      tick    <= 1'b0;
    end else if (count_q >= limit) begin
      count_q <= {CNT_W{1'b0}};
      tick    <= 1'b1;
    end else begin
      count_q <= count_q + {{(CNT_W-1){1'b0}}, 1'b1};
      tick    <= 1'b0;
    end
  end

endmodule // adc_clock_divider

`default_nettype wire

/* File: logic/sar_adc_conversion_control.v */
/*
  Conversion control for a 10-bit successive-approximation converter:
  start pulse detection, busy flag, sample and convert sequencing,
  power gating, analog selection decode and result byte layout.
  Assumes control bits from same-clock logic; the comparator output
  from the analog core is asynchronous and is synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sar_adc_defs.vh"

module sar_adc_conversion_control (
  input  wire       clock,
  input  wire       rst,
  input  wire       start_bit,
  input  wire       converter_power_enable,
  input  wire       result_format_select,
  input  wire [2:0] clock_divide_select,
  input  wire [2:0] input_source_select,
  input  wire [3:0] external_channel_select,
  input  wire [1:0] reference_select,
  input  wire       global_interrupt_enable,
  input  wire       conversion_interrupt_enable,
  input  wire       request_flag_clear,
  input  wire       comparator_in,
  output reg        conversion_busy_flag,
  output reg        conversion_request_flag,
  output reg        conversion_interrupt,
  output reg  [7:0] result_high_byte,
  output reg  [7:0] result_low_byte,
  output reg        analog_power_on,
  output reg        sample_hold,
  output reg  [9:0] dac_code,
  output reg  [7:0] channel_connect,
  output reg  [2:0] input_mux_sel,
  output reg  [2:0] reference_mux_sel
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam ST_IDLE    = 2'h0;
  localparam ST_SAMPLE  = 2'h1;
  localparam ST_CONVERT = 2'h2;

  reg  [1:0] state_q;
  reg  [3:0] phase_count_q;
  reg  [9:0] sar_q;
  reg  [3:0] bit_index_q;
  reg        start_prev_q;
  reg        start_armed_q;
  reg        comp_meta_q;
  reg        comp_sync_q;
  wire       adc_tick;
  wire       start_fire;
  wire       finish;

  // ----------------------------------------------------------------
  // Converter clock
  // ----------------------------------------------------------------
  adc_clock_divider #(
    .SEL_W (`DIV_WIDTH),
    .CNT_W (`DIV_COUNT_WIDTH)
  ) u_div (
    .clock       (clock),
    .rst         (rst),
    .clear       (state_q == ST_IDLE),
    .divide_code (clock_divide_select),
    .tick        (adc_tick)
  );

  // ----------------------------------------------------------------
  // Start pulse detect: rise arms, fall triggers
  // ----------------------------------------------------------------
  assign start_fire = start_armed_q & start_prev_q & ~start_bit;

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      start_prev_q  <= 1'b0;
      start_armed_q <= 1'b0;
    end else begin
      start_prev_q <= start_bit;
      if (!converter_power_enable) begin
        start_armed_q <= 1'b0;
      end else if (start_bit & ~start_prev_q) begin
        start_armed_q <= 1'b1;
      end else if (start_fire) begin
        start_armed_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Comparator synchroniser
  // ----------------------------------------------------------------
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      comp_meta_q <= 1'b0;
      comp_sync_q <= 1'b0;
    end else begin
      comp_meta_q <= comparator_in;
      comp_sync_q <= comp_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  assign finish = (state_q == ST_CONVERT) & adc_tick &
                  (phase_count_q == `CONVERT_CYCLES - 4'h1);

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q       <= ST_IDLE;
      phase_count_q <= 4'h0;
      sar_q         <= 10'h000;
      bit_index_q   <= 4'h0;
    end else if (!converter_power_enable) begin
      state_q       <= ST_IDLE;
      phase_count_q <= 4'h0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start_fire) begin
            state_q       <= ST_SAMPLE;
            phase_count_q <= 4'h0;
          end
        end
        ST_SAMPLE: begin
          if (adc_tick) begin
            if (phase_count_q == `SAMPLE_CYCLES - 4'h1) begin
              state_q       <= ST_CONVERT;
              phase_count_q <= 4'h0;
              sar_q         <= 10'h200;
              bit_index_q   <= 4'h9;
            end else begin
              phase_count_q <= phase_count_q + 4'h1;
            end
          end
        end
        ST_CONVERT: begin
          if (adc_tick) begin
            // Keep trial bit if input at or above trial level, then try next
            sar_q[bit_index_q] <= comp_sync_q;
            if (bit_index_q != 4'h0) begin
              sar_q[bit_index_q - 4'h1] <= 1'b1;
              bit_index_q <= bit_index_q - 4'h1;
            end
            if (finish) begin
              state_q <= ST_IDLE;
            end else begin
              phase_count_q <= phase_count_q + 4'h1;
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Busy, request, interrupt, result
  // ----------------------------------------------------------------
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      conversion_busy_flag    <= 1'b0;
      conversion_request_flag <= 1'b0;
      conversion_interrupt    <= 1'b0;
      result_high_byte        <= 8'h00;
      result_low_byte         <= 8'h00;
    end else begin
      if (!converter_power_enable || finish) begin
        conversion_busy_flag <= 1'b0;
      end else if (state_q == ST_IDLE && start_fire) begin
        conversion_busy_flag <= 1'b1;
      end
      // Set wins over clear
      if (finish) begin
        conversion_request_flag <= 1'b1;
      end else if (request_flag_clear) begin
        conversion_request_flag <= 1'b0;
      end
      conversion_interrupt <= (conversion_request_flag | finish) &
                              global_interrupt_enable &
                              conversion_interrupt_enable;
      if (finish) begin
        // Final bit folded in; result stands with busy falling
        if (result_format_select) begin
          result_high_byte <= {6'h00, sar_q[9:8]};
          result_low_byte  <= {sar_q[7:1], comp_sync_q};
        end else begin
          result_high_byte <= sar_q[9:2];
          result_low_byte  <= {6'h00, sar_q[1], comp_sync_q};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Analog core controls
  // ----------------------------------------------------------------
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      analog_power_on   <= 1'b0;
      sample_hold       <= 1'b0;
      dac_code          <= 10'h000;
      channel_connect   <= 8'h00;
      input_mux_sel     <= 3'h0;
      reference_mux_sel <= 3'h0;
    end else begin
      analog_power_on <= converter_power_enable;
      sample_hold     <= converter_power_enable & (state_q == ST_SAMPLE);
      dac_code        <= sar_q;
      if (!converter_power_enable) begin
        input_mux_sel     <= 3'h0;
        reference_mux_sel <= 3'h0;
        channel_connect   <= 8'h00;
      end else begin
        if (input_source_select == `SRC_VDD4) begin
          input_mux_sel <= 3'h1 << `MUX_VDD4;
        end else if (input_source_select >= `SRC_GND_LO &&
                     input_source_select <= `SRC_GND_HI) begin
          input_mux_sel <= 3'h1 << `MUX_GND;
        end else begin
          input_mux_sel <= 3'h1 << `MUX_EXT;
        end
        if (reference_select == `REF_VDD) begin
          reference_mux_sel <= 3'h1 << `REF_SEL_VDD;
        end else if (reference_select == `REF_AMP) begin
          reference_mux_sel <= 3'h1 << `REF_SEL_AMP;
        end else begin
          reference_mux_sel <= 3'h1 << `REF_SEL_PIN;
        end
        if (!external_channel_select[3] &&
            (input_source_select == `SRC_EXT0 ||
             input_source_select > `SRC_VDD4)) begin
          channel_connect <= 8'h01 << external_channel_select[2:0];
        end else begin
          channel_connect <= 8'h00;
        end
      end
    end
  end

endmodule // sar_adc_conversion_control

`default_nettype wire

/* File: verif/sar_adc_properties.sv */
/* Port checker for the conversion control block.
   Assumes a bind onto sar_adc_conversion_control and one clock. */
`timescale 1ns/1ps
`default_nettype none
module sar_adc_checker (
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       start_bit,
  input wire logic       converter_power_enable,
  input wire logic [2:0] input_source_select,
  input wire logic [3:0] external_channel_select,
  input wire logic [1:0] reference_select,
  input wire logic       global_interrupt_enable,
  input wire logic       conversion_interrupt_enable,
  input wire logic       conversion_busy_flag,
  input wire logic       conversion_request_flag,
  input wire logic       conversion_interrupt,
  input wire logic [7:0] channel_connect,
  input wire logic [2:0] input_mux_sel,
  input wire logic [2:0] reference_mux_sel,
  input wire logic       analog_power_on,
  input wire logic       sample_hold
);
  logic       pw_q;
  wire        pw    = converter_power_enable;
  wire        on    = pw && pw_q;
  wire        ext   = input_source_select == 3'h0 || input_source_select >= 3'h5;
  wire  [2:0] e_src = ext ? 3'h1 : (input_source_select == 3'h4 ? 3'h4 : 3'h2);
  wire  [2:0] e_ref = reference_select == 2'h1 ? 3'h2 : (reference_select == 2'h2 ? 3'h4 : 3'h1);
  wire  [7:0] e_ch  = (ext && !external_channel_select[3]) ?
                      (8'h01 << external_channel_select[2:0]) : 8'h00;
  always @(posedge clock or posedge rst) begin
    if (rst) pw_q <= 1'h0;
    else pw_q <= pw;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  a_idle_unpowered: assert property (!pw |=> !conversion_busy_flag)
    else $error("busy while unpowered");
  a_busy_after_fall: assert property ($rose(conversion_busy_flag) |-> !$past(start_bit))
    else $error("busy rose without start fall");
  a_request_at_end: assert property ($fell(conversion_busy_flag) && on |-> conversion_request_flag)
    else $error("no request at completion");
  a_irq_needs_enables: assert property (conversion_interrupt |->
    $past(global_interrupt_enable && conversion_interrupt_enable))
    else $error("interrupt without enables");
  a_irq_follows_flag: assert property (
    $past(conversion_request_flag && global_interrupt_enable && conversion_interrupt_enable)
    |-> conversion_interrupt)
    else $error("interrupt missing");
  a_mux_unpowered: assert property (!pw && !pw_q |-> input_mux_sel == 3'h0 &&
    reference_mux_sel == 3'h0 && channel_connect == 8'h00)
    else $error("analog path live while off");
  a_power_follows: assert property (analog_power_on == $past(converter_power_enable))
    else $error("power control does not follow enable");
  a_hold_in_busy: assert property (sample_hold |-> conversion_busy_flag)
    else $error("sampling outside a conversion");
  a_ref_decode: assert property (on && $stable(reference_select) |-> reference_mux_sel == e_ref)
    else $error("reference decode wrong");
  a_src_decode: assert property (on && $stable(input_source_select) |-> input_mux_sel == e_src)
    else $error("source decode wrong");
  a_chan_decode: assert property (on && $stable(input_source_select) &&
    $stable(external_channel_select) |-> channel_connect == e_ch)
    else $error("channel decode wrong");
endmodule // sar_adc_checker
bind sar_adc_conversion_control sar_adc_checker sar_adc_checker_inst (.*);
`default_nettype wire

/* File: verif/analog_core_model.sv */
/* Comparator side of the converter core.
   Assumes one-hot source select and a held input per sampling phase. */
`timescale 1ns/1ps
`default_nettype none
module analog_core_model #(
  parameter [9:0] QUARTER_SUPPLY = 10'h100
) (
  input  wire logic       clock,
  input  wire logic [9:0] dac_code,
  input  wire logic       analog_power_on,
  input  wire logic       sample_hold,
  input  wire logic [2:0] input_mux_sel,
  input  wire logic [9:0] pin_level,
  output wire logic       comparator_in
);
  logic [9:0] held;
  logic       junk = 1'h0;
  always @(posedge clock) begin
    junk <= ~junk;
    if (sample_hold) held <= input_mux_sel[2] ? QUARTER_SUPPLY :
                             (input_mux_sel[1] ? 10'h000 : pin_level);
  end
  // Unpowered core gives a toggling, meaningless answer
  assign comparator_in = analog_power_on ? (dac_code <= held) : junk;
endmodule // analog_core_model
`default_nettype wire

/* File: verif/tb.sv */
/* Self-checking bench for the conversion control block.
   Assumes the analog core model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module tb;
  logic clock = 0, rst = 1, start_bit = 0, converter_power_enable = 0, result_format_select = 0;
  logic [2:0] clock_divide_select = 0, input_source_select = 0;
  logic [3:0] external_channel_select = 0;
  logic [1:0] reference_select = 0;
  logic global_interrupt_enable = 0, conversion_interrupt_enable = 0, request_flag_clear = 0;
  logic comparator_in, conversion_busy_flag, conversion_request_flag, conversion_interrupt;
  logic analog_power_on, sample_hold;
  logic [7:0] result_high_byte, result_low_byte, channel_connect;
  logic [2:0] input_mux_sel, reference_mux_sel;
  logic [9:0] dac_code, lv, pin_level = 0;
  logic [24:0] rows [8];
  int n_mismatch = 0, check_count = 0, i, n, ex;
  sar_adc_conversion_control sar_adc_conversion_control_inst (.*);
  analog_core_model analog_core_model_inst (.*);
  always #2 clock = ~clock;
  task results;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic convert(output int n);
    int w;
    w = 0;
    n = 0;
    @(posedge clock) start_bit <= 1'h1;
    @(posedge clock) start_bit <= 1'h0;
    while (conversion_busy_flag !== 1'h1 && w < 8) begin @(posedge clock); #1; w++; end
    while (conversion_busy_flag === 1'h1 && n < 2000) begin @(posedge clock); #1; n++; end
  endtask
  initial begin
    #200000 n_mismatch++;
    $display("watchdog expired");
    results;
  end
  // ----
  // Rows: divide, format, source, channel, reference, enables, level
  // Divide codes 2 and up leave the comparator path time to settle
  // Rows with an internal source also park the channel
  // No pin sharing here, so internal references never meet the pin
  // ----
  initial begin
    rows = '{{3'h2,1'h0,3'h0,4'h0,2'h0,2'h3,10'h3FF}, {3'h3,1'h1,3'h1,4'h8,2'h1,2'h2,10'h155},
             {3'h2,1'h0,3'h2,4'h9,2'h2,2'h1,10'h2AA}, {3'h3,1'h1,3'h3,4'hF,2'h3,2'h0,10'h001},
             {3'h4,1'h0,3'h4,4'h8,2'h1,2'h3,10'h000}, {3'h5,1'h1,3'h5,4'h7,2'h2,2'h3,10'h3FE},
             {3'h6,1'h0,3'h6,4'h3,2'h0,2'h0,10'h200}, {3'h7,1'h1,3'h7,4'h5,2'h3,2'h3,10'h0F0}};
    repeat (2) @(posedge clock);
    rst <= 1'h0;
    #1 `CHK("reset state", 17'h0, {conversion_busy_flag, result_high_byte, result_low_byte})
    $display("reset test done");
    @(posedge clock) converter_power_enable <= 1'h1;
    repeat (4) @(posedge clock);
    // Fastest divide codes: busy span only, results not meaningful
    for (i = 0; i < 2; i++) begin
      clock_divide_select <= i[2:0];
      convert(n);
      `CHK("fast busy span", 1'h1, n >= (14 << i) - 3 && n <= (14 << i) + 3)
      @(posedge clock);
    end
    $display("fast divide spans done");
    for (i = 0; i < 8; i++) begin
      @(posedge clock);
      {clock_divide_select, result_format_select, input_source_select,
       external_channel_select, reference_select, global_interrupt_enable,
       conversion_interrupt_enable, pin_level} <= rows[i];
      request_flag_clear <= 1'h1;
      @(posedge clock) request_flag_clear <= 1'h0;
      @(posedge clock) #1 `CHK("request cleared", 1'h0, conversion_request_flag)
      convert(n);
      lv = rows[i][20:18] == 3'h4 ? 10'h100 :
           (rows[i][20:18] inside {[3'h1:3'h3]} ? 10'h000 : rows[i][9:0]);
      ex = 14 << rows[i][24:22];
      `CHK("busy span", 1'h1, n >= ex - 3 && n <= ex + 3)
      `CHK("high byte", rows[i][21] ? {6'h0, lv[9:8]} : lv[9:2], result_high_byte)
      `CHK("low byte", rows[i][21] ? lv[7:0] : {6'h0, lv[1:0]}, result_low_byte)
      `CHK("request", 1'h1, conversion_request_flag)
      @(posedge clock) #1 `CHK("interrupt", &rows[i][11:10], conversion_interrupt)
      `CHK("final trial code", lv, dac_code)
      $display("row %0d done", i);
    end
    @(posedge clock) start_bit <= 1'h1;
    repeat (20) @(posedge clock);
    #1 `CHK("held start idle", 1'h0, conversion_busy_flag)
    @(posedge clock) start_bit <= 1'h0;
    repeat (30) @(posedge clock);
    #1 `CHK("busy on fall", 1'h1, conversion_busy_flag)
    @(posedge clock) converter_power_enable <= 1'h0;
    repeat (3) @(posedge clock);
    #1 `CHK("abort idle", 1'h0, conversion_busy_flag)
    `CHK("result kept", 16'h00F0, {result_high_byte, result_low_byte})
    convert(n);
    `CHK("deaf unpowered", 0, n)
    $display("awkward cases done");
    results;
  end
endmodule // tb
`default_nettype wire
